// *** hw/usb_irq_pkg.sv ***
// Constants, register map and carrier types for the USB interrupt gating block
package usb_irq_pkg;

    // Register bus geometry
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned DATA_W = 32;

    // Register byte addresses
    localparam logic [31:0] PENDING_STATUS_ADDR = 32'h4008_0020;
    localparam logic [31:0] SOURCE_ENABLE_ADDR = 32'h4008_0024;
    localparam logic [31:0] PENDING_SET_ADDR = 32'h4008_0028;
    localparam logic [31:0] LINE_SELECT_ADDR = 32'h4008_002C;
    localparam logic [31:0] ACTIVE_VIEW_ADDR = 32'h4008_0030;
    localparam logic [31:0] TOGGLE_VIEW_ADDR = 32'h4008_0034;

    // Source layout inside a 32-bit register word
    localparam int unsigned EP_COUNT = 10;
    localparam int unsigned EP_LSB = 0;
    localparam int unsigned EP_MSB = 9;
    localparam int unsigned SOF_BIT = 30;
    localparam int unsigned DEV_BIT = 31;
    localparam int unsigned SOURCE_COUNT = 12;

    // Implemented bits of the enable, set-pending, routing and status words
    localparam logic [31:0] IMPL_MASK = 32'hC000_03FF;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    localparam logic [9:0] TOGGLE_RESET = 10'h000;

    // Routing bit encoding
    localparam logic LINE_NORMAL = 1'h0;
    localparam logic LINE_FAST = 1'h1;

    // One bit per interrupt source, compact order
    typedef struct packed {
        logic dev;
        logic sof;
        logic [9:0] ep;
    } source_vec_s;

    // One register bus request
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    // Spread a compact source vector into the register word layout
    function automatic logic [31:0] to_word(input source_vec_s v);
        logic [31:0] w;
        w = WORD_RESET;
        w[EP_MSB:EP_LSB] = v.ep;
        w[SOF_BIT] = v.sof;
        w[DEV_BIT] = v.dev;
        return w;
    endfunction : to_word

    // Gather the implemented bits of a register word into a source vector
    function automatic source_vec_s from_word(input logic [31:0] w);
        source_vec_s v;
        v.ep = w[EP_MSB:EP_LSB];
        v.sof = w[SOF_BIT];
        v.dev = w[DEV_BIT];
        return v;
    endfunction : from_word

endpackage : usb_irq_pkg

// *** hw/irq_pending_bit.sv ***
// One sticky pending flag: hardware or software sets it, software clears it
`timescale 1ns/10ps
module irq_pending_bit (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Set and clear requests
    input wire logic hwSet,
    input wire logic swSet,
    input wire logic swClear,
    // Flag
    output logic pending
);

    logic pending_reg;
    logic pending_next;

    // A set arriving in the clearing cycle wins so no event is lost
    always_comb
    begin
        pending_next = (pending_reg & ~swClear) | hwSet | swSet;
    end

    // Flag storage
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pending_reg <= 1'b0;
        end
        else
        begin
            pending_reg <= pending_next;
        end
    end

    assign pending = pending_reg;

endmodule : irq_pending_bit

// *** hw/irq_source_gate.sv ***
// Gates one pending source by its enable and steers it to a line
`timescale 1ns/10ps
module irq_source_gate (
    // Source state
    input wire logic pending,
    input wire logic enable,
    input wire logic lineSelect,
    // Steered requests
    output logic active,
    output logic toNormal,
    output logic toFast
);

    // Both bits must be set before the source may request
    assign active = pending & enable;
    assign toNormal = active & (lineSelect == usb_irq_pkg::LINE_NORMAL);
    assign toFast = active & (lineSelect == usb_irq_pkg::LINE_FAST);

endmodule : irq_source_gate

// *** hw/usb_irq_enable_route_toggle.sv ***
// Interrupt enable, set-pending, routing and toggle view of a USB device controller
//
// Functional notes
// - Endpoint source 0..9 requests only when its enable and pending bits are one.
// - Frame source bit 30 and device source bit 31 each have own enables.
// - Writing one to set-pending bits 9:0, 30, 31 sets the pending flag.
// - Reading set-pending returns the live pending status, nothing stored separately.
// - Routing bit zero selects the normal line, one selects the fast line.
// - Toggle view bits 9:0 show endpoint data toggles; bits 31:10 read zero.
// - Bits 29:10 of enable, set-pending, routing read zero; enables and routes reset zero.
// - Writing one to a pending status bit clears it; zero leaves it.
// - Pending bits 0..9 are endpoint directions, 30 frame, 31 device change.
//
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
module usb_irq_enable_route_toggle (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Register bus
    input wire logic [31:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // Hardware events from the protocol and list engines
    input wire usb_irq_pkg::source_vec_s hwEvent,
    // Current data toggles of the ten endpoint directions
    input wire logic [9:0] endpointToggle,
    // Processor interrupt lines
    output logic normalInterruptLine,
    output logic fastInterruptLine
);

    // Bus request bundle
    usb_irq_pkg::reg_req_s busReq;

    // Address decode strobes
    logic hitStatus;
    logic hitEnable;
    logic hitSet;
    logic hitSelect;
    logic hitActive;
    logic hitToggle;
    logic wrStatus;
    logic wrEnable;
    logic wrSet;
    logic wrSelect;

    // Software-owned control words
    logic [31:0] irq_source_enable_reg;
    logic [31:0] irq_source_enable_next;
    logic [31:0] irq_line_select_reg;
    logic [31:0] irq_line_select_next;

    // Toggle snapshot feeding the read path
    logic [9:0] endpoint_toggle_view_reg;

    // Read path
    logic [31:0] regRdata_reg;
    logic [31:0] regRdata_next;

    // Per-source views in compact order
    usb_irq_pkg::source_vec_s endpointSourceEnables;
    usb_irq_pkg::source_vec_s lineSelectVec;
    usb_irq_pkg::source_vec_s forcePending;
    usb_irq_pkg::source_vec_s clearPending;
    usb_irq_pkg::source_vec_s irqPendingStatus;
    usb_irq_pkg::source_vec_s activeVec;
    usb_irq_pkg::source_vec_s normalVec;
    usb_irq_pkg::source_vec_s fastVec;

    // Word images for read-back
    logic [31:0] pendingWord;
    logic [31:0] activeWord;
    logic [31:0] toggleWord;

    // Pack the bus ports into one request
    always_comb
    begin
        busReq.addr = regAddr;
        busReq.wdata = regWdata;
        busReq.wr = regWr;
        busReq.rd = regRd;
    end

    // Full address compare; anything unmatched is ignored on write and reads zero
    always_comb
    begin
        hitStatus = (busReq.addr == usb_irq_pkg::PENDING_STATUS_ADDR);
        hitEnable = (busReq.addr == usb_irq_pkg::SOURCE_ENABLE_ADDR);
        hitSet = (busReq.addr == usb_irq_pkg::PENDING_SET_ADDR);
        hitSelect = (busReq.addr == usb_irq_pkg::LINE_SELECT_ADDR);
        hitActive = (busReq.addr == usb_irq_pkg::ACTIVE_VIEW_ADDR);
        hitToggle = (busReq.addr == usb_irq_pkg::TOGGLE_VIEW_ADDR);
    end

    // Write strobes; read-only words never see one
    always_comb
    begin
        wrStatus = busReq.wr & hitStatus;
        wrEnable = busReq.wr & hitEnable;
        wrSet = busReq.wr & hitSet;
        wrSelect = busReq.wr & hitSelect;
    end

    // Enable word: reserved bits are masked off so they stay zero
    always_comb
    begin
        irq_source_enable_next = irq_source_enable_reg;
        if (wrEnable)
        begin
            irq_source_enable_next = busReq.wdata & usb_irq_pkg::IMPL_MASK;
        end
    end

    // Enable word storage
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irq_source_enable_reg <= usb_irq_pkg::WORD_RESET;
        end
        else
        begin
            irq_source_enable_reg <= irq_source_enable_next;
        end
    end

    // Routing word: same masking as the enable word
    always_comb
    begin
        irq_line_select_next = irq_line_select_reg;
        if (wrSelect)
        begin
            irq_line_select_next = busReq.wdata & usb_irq_pkg::IMPL_MASK;
        end
    end

    // Routing word storage
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irq_line_select_reg <= usb_irq_pkg::WORD_RESET;
        end
        else
        begin
            irq_line_select_reg <= irq_line_select_next;
        end
    end

    // Snapshot of the toggle state; costs one cycle of latency on the view
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            endpoint_toggle_view_reg <= usb_irq_pkg::TOGGLE_RESET;
        end
        else
        begin
            endpoint_toggle_view_reg <= endpointToggle;
        end
    end

    // Bring the control words and software requests into source order
    always_comb
    begin
        endpointSourceEnables = usb_irq_pkg::from_word(irq_source_enable_reg);
        lineSelectVec = usb_irq_pkg::from_word(irq_line_select_reg);
        forcePending = usb_irq_pkg::from_word(wrSet ? busReq.wdata : usb_irq_pkg::WORD_RESET);
        clearPending = usb_irq_pkg::from_word(wrStatus ? busReq.wdata : usb_irq_pkg::WORD_RESET);
    end

    // One sticky flag and one gate per implemented source
    for (genvar i = 0; i < usb_irq_pkg::SOURCE_COUNT; i++)
    begin : g_source
        irq_pending_bit u_pending (
            .mclk(mclk),
            .rst_b(rst_b),
            .hwSet(hwEvent[i]),
            .swSet(forcePending[i]),
            .swClear(clearPending[i]),
            .pending(irqPendingStatus[i])
        );

        irq_source_gate u_gate (
            .pending(irqPendingStatus[i]),
            .enable(endpointSourceEnables[i]),
            .lineSelect(lineSelectVec[i]),
            .active(activeVec[i]),
            .toNormal(normalVec[i]),
            .toFast(fastVec[i])
        );
    end

    // Word images; the status word places bits per the source layout
    always_comb
    begin
        pendingWord = usb_irq_pkg::to_word(irqPendingStatus);
        activeWord = usb_irq_pkg::to_word(activeVec);
        // Upper toggle bits stay at the reset word so they always read zero
        toggleWord = usb_irq_pkg::WORD_RESET;
        toggleWord[usb_irq_pkg::EP_MSB:usb_irq_pkg::EP_LSB] = endpoint_toggle_view_reg;
    end

    // Read mux; set-pending has no storage of its own and mirrors the status
    always_comb
    begin
        regRdata_next = usb_irq_pkg::WORD_RESET;
        if (busReq.rd)
        begin
            case (1'b1)
                hitStatus: regRdata_next = pendingWord;
                hitEnable: regRdata_next = irq_source_enable_reg;
                hitSet: regRdata_next = pendingWord;
                hitSelect: regRdata_next = irq_line_select_reg;
                hitActive: regRdata_next = activeWord;
                hitToggle: regRdata_next = toggleWord;
                default: regRdata_next = usb_irq_pkg::WORD_RESET;
            endcase
        end
    end

    // Read data stand for one cycle after the strobe, zero otherwise
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            regRdata_reg <= usb_irq_pkg::WORD_RESET;
        end
        else
        begin
            regRdata_reg <= regRdata_next;
        end
    end

    assign regRdata = regRdata_reg;

    // Level lines follow the gated sources with no added latency
    assign normalInterruptLine = |normalVec;
    assign fastInterruptLine = |fastVec;

endmodule : usb_irq_enable_route_toggle

// *** tb/usb_irq_chk.sv ***
// Port checker for the USB interrupt gating block
`timescale 1ns/10ps
module usb_irq_chk (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Register bus
    input wire logic [31:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdata,
    // Events, toggles and lines
    input wire usb_irq_pkg::source_vec_s hwEvent,
    input wire logic [9:0] endpointToggle,
    input wire logic normalInterruptLine,
    input wire logic fastInterruptLine
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    // Read data stands only in the slot after a strobe
    rdata_slot_a: assert property (regRdata != 32'h0 |-> $past(regRd)) else $error("stray data");
    reserved_zero_a: assert property ($past(regRd) |-> regRdata[29:10] == 20'h0) else $error("reserved set");
    toggle_view_a: assert property ($past(regRd) && $past(regAddr) == 32'h4008_0034
        |-> regRdata == {22'h0, $past(endpointToggle, 2)}) else $error("toggle view");
    // Anything outside the mapped window must read zero
    unmapped_zero_a: assert property ($past(regRd)
        && ($past(regAddr) < 32'h4008_0020 || $past(regAddr) > 32'h4008_0034)
        |-> regRdata == 32'h0) else $error("unmapped read");
    // A line only moves when software writes or hardware raises an event
    norm_rise_a: assert property ($rose(normalInterruptLine)
        |-> $past(regWr) || $past(hwEvent) != 12'h000) else $error("normal rise");
    fast_rise_a: assert property ($rose(fastInterruptLine)
        |-> $past(regWr) || $past(hwEvent) != 12'h000) else $error("fast rise");
    norm_fall_a: assert property ($fell(normalInterruptLine) |-> $past(regWr)) else $error("normal fall");
    clear_all_a: assert property (regWr && regAddr == 32'h4008_0020 && regWdata == 32'hFFFF_FFFF
        && hwEvent == 12'h000 |=> !normalInterruptLine && !fastInterruptLine) else $error("lines stay");

    // Main scenarios
    cover property ($rose(normalInterruptLine));
    cover property ($rose(fastInterruptLine));
    cover property ($past(regRd) && regRdata != 32'h0);
endmodule : usb_irq_chk

bind usb_irq_enable_route_toggle usb_irq_chk i_chk (.mclk, .rst_b, .regAddr, .regWdata, .regWr,
    .regRd, .regRdata, .hwEvent, .endpointToggle, .normalInterruptLine, .fastInterruptLine);

// *** tb/irq_cpu_model.sv ***
// Processor side model that samples both interrupt lines
`timescale 1ns/10ps
module irq_cpu_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Lines from the block
    input wire logic normalInterruptLine,
    input wire logic fastInterruptLine,
    // Lines as taken by the core
    output logic [1:0] takenReg
);
    // Core samples levels on the clock, so a line must stand a whole cycle
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            takenReg <= 2'h0;
        else
            takenReg <= {fastInterruptLine, normalInterruptLine};
    end
endmodule : irq_cpu_model

// *** tb/tb_top.sv ***
// Self-checking bench for the USB interrupt gating block
`timescale 1ns/10ps
module tb_top;
    localparam logic [31:0] STA = usb_irq_pkg::PENDING_STATUS_ADDR;
    localparam logic [31:0] EN = usb_irq_pkg::SOURCE_ENABLE_ADDR;
    localparam logic [31:0] SET = usb_irq_pkg::PENDING_SET_ADDR;
    localparam logic [31:0] RTE = usb_irq_pkg::LINE_SELECT_ADDR;
    localparam logic [31:0] TGL = usb_irq_pkg::TOGGLE_VIEW_ADDR;
    localparam logic [31:0] ACT = usb_irq_pkg::ACTIVE_VIEW_ADDR;
    logic mclk = 1'h0;
    logic rst_b = 1'h0;
    logic [31:0] regAddr = 32'h0;
    logic [31:0] regWdata = 32'h0;
    logic regWr = 1'h0;
    logic regRd = 1'h0;
    logic [31:0] regRdata;
    usb_irq_pkg::source_vec_s hwEvent = 12'h000;
    logic [9:0] endpointToggle = 10'h000;
    logic normalInterruptLine;
    logic fastInterruptLine;
    logic [1:0] takenReg;
    int badCount = 0;
    int nCompared = 0;
    int cycles = 0;
    int srcBit [12] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 30, 31};

    usb_irq_enable_route_toggle i_dut (.mclk, .rst_b, .regAddr, .regWdata, .regWr, .regRd,
        .regRdata, .hwEvent, .endpointToggle, .normalInterruptLine, .fastInterruptLine);
    irq_cpu_model i_cpu (.mclk, .rst_b, .normalInterruptLine, .fastInterruptLine, .takenReg);

    // 125 MHz clock
    initial
    begin
        forever #4 mclk = ~mclk;
    end

    task automatic stopTest;
        if (badCount == 0 && nCompared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stopTest

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp)
        begin
            badCount++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        regWr <= 1'h1;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk);
        regWr <= 1'h0;
    endtask : wr

    // Data stands only in the cycle after the strobe edge
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        @(posedge mclk);
        regRd <= 1'h1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'h0;
        #1;
        check($sformatf("read %h", a), regRdata, exp);
    endtask : rd

    // Lines now, then as the core took them one edge later
    task automatic lines(input logic [1:0] exp);
        #1;
        check("lines", 32'({fastInterruptLine, normalInterruptLine}), 32'(exp));
        @(posedge mclk);
        #1;
        check("taken", 32'(takenReg), 32'(exp));
    endtask : lines

    task automatic resetValues;
        foreach (srcBit[i])
            rd(32'h4008_0020 + 32'(i % 6) * 32'h4, 32'h0);
    endtask : resetValues

    task automatic reservedBits;
        wr(EN, 32'hFFFF_FFFF);
        wr(RTE, 32'hFFFF_FFFF);
        wr(32'h4008_0038, 32'hFFFF_FFFF);
        rd(EN, 32'hC000_03FF);
        rd(RTE, 32'hC000_03FF);
        rd(32'h4008_0038, 32'h0);
        wr(EN, 32'h0);
        wr(RTE, 32'h0);
    endtask : reservedBits

    // Every source through set, route, gate and clear
    task automatic sourceWalk;
        logic [31:0] m;
        foreach (srcBit[i])
        begin
            m = 32'h1 << srcBit[i];
            wr(EN, m);
            wr(SET, m);
            lines(2'h1);
            rd(ACT, m);
            rd(SET, m);
            rd(STA, m);
            wr(RTE, m);
            lines(2'h2);
            wr(EN, 32'h0);
            lines(2'h0);
            rd(ACT, 32'h0);
            wr(STA, ~m);
            rd(STA, m);
            wr(STA, m);
            rd(SET, 32'h0);
            wr(RTE, 32'h0);
        end
    endtask : sourceWalk

    // Hardware pulses on two sources, lines split then cleared
    task automatic hwEvents;
        wr(EN, 32'hC000_03FF);
        @(posedge mclk);
        hwEvent <= 12'h004;
        @(posedge mclk);
        hwEvent <= 12'h800;
        @(posedge mclk);
        hwEvent <= 12'h000;
        rd(STA, 32'h8000_0004);
        wr(RTE, 32'h8000_0000);
        lines(2'h3);
        wr(STA, 32'h8000_0000);
        lines(2'h1);
        wr(STA, 32'hFFFF_FFFF);
        lines(2'h0);
        // Event and clear at the same edge: the event must survive
        @(posedge mclk);
        hwEvent <= 12'h004;
        regWr <= 1'h1;
        regAddr <= STA;
        regWdata <= 32'h0000_0004;
        @(posedge mclk);
        hwEvent <= 12'h000;
        regWr <= 1'h0;
        rd(STA, 32'h0000_0004);
        lines(2'h1);
        wr(STA, 32'h0000_0004);
        lines(2'h0);
        wr(EN, 32'h0);
        wr(RTE, 32'h0);
    endtask : hwEvents

    // Toggle view follows its input and ignores writes
    task automatic toggleView;
        @(posedge mclk);
        endpointToggle <= 10'h2A5;
        wr(TGL, 32'h0);
        rd(TGL, 32'h0000_02A5);
        @(posedge mclk);
        endpointToggle <= 10'h15A;
        repeat (2) @(posedge mclk);
        rd(TGL, 32'h0000_015A);
    endtask : toggleView

    initial
    begin
        repeat (20) @(posedge mclk);
        rst_b <= 1'h1;
        resetValues();
        reservedBits();
        sourceWalk();
        hwEvents();
        toggleView();
        stopTest();
    end

    // The run needs well under a thousand cycles
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            badCount++;
            stopTest();
        end
    end
endmodule : tb_top
